// File: awm_defines.svh
`ifndef AWM_DEFINES_SVH
`define AWM_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define AWM_CLK_MHZ          200
`define AWM_CONFIRM_MS       2000
`define AWM_CONFIRM_CYCLES   (`AWM_CONFIRM_MS * 1000 * `AWM_CLK_MHZ)
`define AWM_ERASE_US         1000
`define AWM_ERASE_CYCLES     (`AWM_ERASE_US * `AWM_CLK_MHZ)

// ----------------------------------------
// History
// ----------------------------------------
`define AWM_HIST_DEPTH       9
`define AWM_CODE_W           8
`define AWM_CODE_NONE        8'h00

// ----------------------------------------
// Warning codes and view selectors
// ----------------------------------------
`define AWM_WARN_HEAT        8'h21
`define AWM_WARN_LOAD        8'h30
`define AWM_WARN_OPERR       8'h6C
`define AWM_VIEW_CONFIRM     2'h1
`define AWM_VIEW_INITIAL     2'h0
`define AWM_VIEW_ALARM       2'h2

`endif

// File: awm_pkg.sv
package awm_pkg;

   typedef enum logic [3:0] {
      AWM_IDLE  = 4'h1,
      AWM_ALARM = 4'h2,
      AWM_CONF  = 4'h4,
      AWM_ERASE = 4'h8
   } awm_state_e;

   typedef struct packed {
      logic fwdRun;
      logic revRun;
      logic faultClear;
      logic panelRun;
   } awm_runin_s;

   typedef struct packed {
      logic clrAlarmCmd;
      logic clrAlarmHistCmd;
      logic clrWarnHistCmd;
      logic extOpMode;
   } awm_panel_s;

   typedef struct packed {
      logic overheat;
      logic overload;
      logic opAssignWhileOn;
   } awm_warnsrc_s;

endpackage

// File: awm_sync.sv
`timescale 1ns/100ps
`default_nettype none

module awm_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] nxt_sync;

   // A bit changes only once the second and third stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         nxt_sync[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : sync_out[i];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s1_ff    <= '0;
         s2_ff    <= '0;
         s3_ff    <= '0;
         sync_out <= '0;
      end else begin
         s1_ff    <= async_in;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         sync_out <= nxt_sync;
      end
   end

endmodule

`default_nettype wire

// File: awm_alarm_warning_manager.sv
// Notes on behaviour
// - A latched alarm clears on the falling edge of the fault clear input, not the rising one.
// - The fault clear input is ignored while any run signal is on.
// - After an input or panel clear the confirm view shows for 2 s, then the initial view.
// - A panel alarm clear is taken only after the run switch has gone from run to standby.
// - In external mode the startup-run fault clears itself once the run signals drop.
// - In panel mode the startup-run fault clears when the run switch goes run to standby.
// - Nine alarms are kept newest first and erased only by the panel history clear.
// - The display blinks for the whole alarm history erase.
// - The warning output is on whenever any warning is active.
// - Overheat and overload raise warnings and the motor keeps running.
// - Assigning a run function to an input already on raises a warning and stops the motor.
// - Nine warnings are kept newest first, cleared by panel command or power loss.
// - The motor is not driven unless exactly one of forward and reverse run is on.
// - The motor is inhibited while any alarm is latched.
`timescale 1ns/100ps
`default_nettype none
`include "awm_defines.svh"

module awm_alarm_warning_manager #(
   parameter int CONFIRM_CYCLES = `AWM_CONFIRM_CYCLES,
   parameter int ERASE_CYCLES   = `AWM_ERASE_CYCLES,
   parameter int DEPTH          = `AWM_HIST_DEPTH
) (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   // Pins from the controller or switches
   input  wire awm_pkg::awm_runin_s    runIn,
   // Panel commands, same clock
   input  wire awm_pkg::awm_panel_s    panel,
   // Fault detection, same clock
   input  wire logic                   alarmEvent,
   input  wire logic [`AWM_CODE_W-1:0] alarmCode,
   input  wire logic                   startupFault,
   input  wire awm_pkg::awm_warnsrc_s  warnSrc,
   // Status
   output logic                        motorEnable,
   output logic                        motorDir,
   output logic                        warning_output,
   output logic                        alarmActive,
   output logic [1:0]                  displayView,
   output logic                        displayBlink,
   output logic [`AWM_CODE_W-1:0]      alarmHistTop,
   output logic [`AWM_CODE_W-1:0]      warnHistTop
);

   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   awm_pkg::awm_runin_s pin;

   awm_sync #(.W($bits(awm_pkg::awm_runin_s))) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in (runIn),
      .sync_out (pin)
   );

   logic runAny;
   logic clrPrev_ff;
   logic panelPrev_ff;
   logic clrFall;
   logic panelToStby;
   assign runAny      = pin.fwdRun | pin.revRun;
   assign clrFall     = clrPrev_ff & ~pin.faultClear;
   assign panelToStby = panelPrev_ff & ~pin.panelRun;

   // ----------------------------------------
   // Alarm state machine
   // ----------------------------------------
   awm_pkg::awm_state_e state_ff;
   awm_pkg::awm_state_e nxt_state;
   logic [31:0]         timer_ff;
   logic [31:0]         nxt_timer;
   logic                armed_ff;
   logic                nxt_armed;
   logic                startup_run_fault_ff;
   logic                nxt_startup;
   logic                pendAlarm_ff;
   logic                nxt_pend;
   logic                clrFault;
   logic                clrAlarm;

   // Clear input only counts while every run signal is off
   assign clrFault = clrFall & ~runAny;
   // Panel clear needs the switch to have passed to standby first
   assign clrAlarm = clrFault | (panel.clrAlarmCmd & armed_ff);

   always_comb begin
      nxt_state   = state_ff;
      nxt_timer   = timer_ff;
      nxt_armed   = armed_ff;
      nxt_startup = startup_run_fault_ff;
      nxt_pend    = pendAlarm_ff;
      if (panelToStby) begin
         nxt_armed = 1'b1;
      end else if (pin.panelRun) begin
         nxt_armed = 1'b0;
      end
      if (startupFault) begin
         nxt_startup = 1'b1;
      end else if (panel.extOpMode && !runAny) begin
         nxt_startup = 1'b0;
      end else if (!panel.extOpMode && panelToStby) begin
         nxt_startup = 1'b0;
      end
      case (state_ff)
         awm_pkg::AWM_IDLE: begin
            if (alarmEvent) begin
               nxt_state = awm_pkg::AWM_ALARM;
            end else if (panel.clrAlarmHistCmd) begin
               nxt_state = awm_pkg::AWM_ERASE;
               nxt_timer = 32'(ERASE_CYCLES);
            end
         end
         awm_pkg::AWM_ALARM: begin
            if (clrAlarm && !alarmEvent) begin
               nxt_state = awm_pkg::AWM_CONF;
               nxt_timer = 32'(CONFIRM_CYCLES);
            end
         end
         awm_pkg::AWM_CONF: begin
            if (alarmEvent) begin
               nxt_state = awm_pkg::AWM_ALARM;
            end else if (timer_ff <= 32'h1) begin
               nxt_state = awm_pkg::AWM_IDLE;
            end else begin
               nxt_timer = timer_ff - 32'h1;
            end
         end
         awm_pkg::AWM_ERASE: begin
            // An alarm mid-erase is held latched so the erase still runs to its end
            if (alarmEvent) begin
               nxt_pend = 1'b1;
            end
            if (timer_ff <= 32'h1) begin
               nxt_state = (alarmEvent || pendAlarm_ff) ? awm_pkg::AWM_ALARM
                                                        : awm_pkg::AWM_IDLE;
               nxt_pend  = 1'b0;
            end else begin
               nxt_timer = timer_ff - 32'h1;
            end
         end
         default: nxt_state = awm_pkg::AWM_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff             <= awm_pkg::AWM_IDLE;
         timer_ff             <= 32'h0;
         armed_ff             <= 1'b0;
         startup_run_fault_ff <= 1'b0;
         pendAlarm_ff         <= 1'b0;
         clrPrev_ff           <= 1'b0;
         panelPrev_ff         <= 1'b0;
      end else begin
         state_ff             <= nxt_state;
         timer_ff             <= nxt_timer;
         armed_ff             <= nxt_armed;
         startup_run_fault_ff <= nxt_startup;
         pendAlarm_ff         <= nxt_pend;
         clrPrev_ff           <= pin.faultClear;
         panelPrev_ff         <= pin.panelRun;
      end
   end

   // ----------------------------------------
   // Alarm and warning histories
   // ----------------------------------------
   // Alarm store stands in for non-volatile cells; reset does not touch it
   logic [`AWM_CODE_W-1:0] alarmHist [DEPTH];
   logic [`AWM_CODE_W-1:0] warnHist  [DEPTH];
   logic [`AWM_CODE_W-1:0] nxtWarnCode;
   logic [2:0]             warnPrev_ff;
   awm_pkg::awm_warnsrc_s  warnRise;
   logic                   eraseDone;
   assign warnRise  = warnSrc & ~warnPrev_ff;
   assign eraseDone = (state_ff == awm_pkg::AWM_ERASE) && (timer_ff <= 32'h1);

   always_comb begin
      nxtWarnCode = `AWM_CODE_NONE;
      if (warnRise.opAssignWhileOn) begin
         nxtWarnCode = `AWM_WARN_OPERR;
      end else if (warnRise.overload) begin
         nxtWarnCode = `AWM_WARN_LOAD;
      end else if (warnRise.overheat) begin
         nxtWarnCode = `AWM_WARN_HEAT;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : gHist
         always_ff @(posedge ref_clk) begin
            if (eraseDone) begin
               // A code arriving as the erase ends survives it
               alarmHist[g] <= (g == 0 && alarmEvent) ? alarmCode : `AWM_CODE_NONE;
            end else if (alarmEvent) begin
               alarmHist[g] <= (g == 0) ? alarmCode : alarmHist[(g == 0) ? 0 : g-1];
            end
         end
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               warnHist[g] <= `AWM_CODE_NONE;
            end else if (panel.clrWarnHistCmd) begin
               // A warning rising with the clear is kept as the only entry
               warnHist[g] <= (g == 0) ? nxtWarnCode : `AWM_CODE_NONE;
            end else if (nxtWarnCode != `AWM_CODE_NONE) begin
               warnHist[g] <= (g == 0) ? nxtWarnCode : warnHist[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Outputs, all registered
   // ----------------------------------------
   logic alarmLatched;
   logic driveOk;
   assign alarmLatched = (state_ff == awm_pkg::AWM_ALARM) | startup_run_fault_ff
                         | pendAlarm_ff;
   // Operation error stops the motor; overheat and overload do not
   assign driveOk = (pin.fwdRun ^ pin.revRun)
                    & ~alarmLatched
                    & ~warnSrc.opAssignWhileOn;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         warnPrev_ff    <= 3'h0;
         motorEnable    <= 1'b0;
         motorDir       <= 1'b0;
         warning_output <= 1'b0;
         alarmActive    <= 1'b0;
         displayView    <= `AWM_VIEW_INITIAL;
         displayBlink   <= 1'b0;
         alarmHistTop   <= `AWM_CODE_NONE;
         warnHistTop    <= `AWM_CODE_NONE;
      end else begin
         warnPrev_ff    <= warnSrc;
         motorEnable    <= driveOk;
         motorDir       <= pin.revRun;
         warning_output <= |warnSrc;
         alarmActive    <= alarmLatched;
         displayView    <= (state_ff == awm_pkg::AWM_CONF) ? `AWM_VIEW_CONFIRM :
                           alarmLatched ? `AWM_VIEW_ALARM : `AWM_VIEW_INITIAL;
         displayBlink   <= (state_ff == awm_pkg::AWM_ERASE);
         alarmHistTop   <= alarmHist[0];
         warnHistTop    <= warnHist[0];
      end
   end

endmodule

`default_nettype wire

// File: awm_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "awm_defines.svh"
module awm_chk #(
   parameter int CONFIRM_CYCLES = 20,
   parameter int ERASE_CYCLES   = 10
) (
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   resetn,
   // Causes
   input wire logic                   alarmEvent,
   input wire logic [`AWM_CODE_W-1:0] alarmCode,
   input wire awm_pkg::awm_warnsrc_s  warnSrc,
   // Status
   input wire logic                   motorEnable,
   input wire logic                   warning_output,
   input wire logic                   alarmActive,
   input wire logic [1:0]             displayView,
   input wire logic                   displayBlink,
   input wire logic [`AWM_CODE_W-1:0] alarmHistTop
);
   int confCnt_ff;
   int blinkCnt_ff;
   // Run lengths are counted, since repetitions cannot reach these spans
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         confCnt_ff  <= 0;
         blinkCnt_ff <= 0;
      end else begin
         confCnt_ff  <= (displayView == 2'h1) ? confCnt_ff + 1 : 0;
         blinkCnt_ff <= displayBlink ? blinkCnt_ff + 1 : 0;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_conf_rise;
      displayView == 2'h1 && $past(displayView) != 2'h1;
   endsequence
   sequence s_alarm_in;
      alarmEvent ##2 1'b1;
   endsequence
   a_warn_follow: assert property (warning_output == $past(|warnSrc))
      else $error("warning output off its sources");
   a_alarm_lock: assert property (alarmEvent |-> ##2 alarmActive && displayView == 2'h2)
      else $error("alarm not latched");
   a_motor_gate: assert property (motorEnable |-> !alarmActive)
      else $error("motor driven while alarm latched");
   a_alarm_hist: assert property (s_alarm_in |-> alarmHistTop == $past(alarmCode, 2))
      else $error("alarm history top wrong");
   a_operr_stop: assert property (warnSrc.opAssignWhileOn [*2] |-> !motorEnable)
      else $error("motor runs on operation error");
   a_conf_hold: assert property (s_conf_rise |-> (displayView == 2'h1) [*8])
      else $error("confirm view too short");
   a_conf_end: assert property ($fell(displayView == 2'h1) |-> displayView == 2'h0
      && confCnt_ff >= CONFIRM_CYCLES - 1 && confCnt_ff <= CONFIRM_CYCLES + 1)
      else $error("confirm view length wrong");
   a_blink_len: assert property ($fell(displayBlink) |-> blinkCnt_ff >= ERASE_CYCLES - 1
      && blinkCnt_ff <= ERASE_CYCLES + 1)
      else $error("erase blink length wrong");
endmodule
bind awm_alarm_warning_manager awm_chk #(
   .CONFIRM_CYCLES(CONFIRM_CYCLES),
   .ERASE_CYCLES  (ERASE_CYCLES)
) u_chk (
   .ref_clk, .resetn, .alarmEvent, .alarmCode, .warnSrc, .motorEnable,
   .warning_output, .alarmActive, .displayView, .displayBlink, .alarmHistTop
);
`default_nettype wire

// File: awm_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module awm_ctrl_model #(
   parameter int HOLD_CYCLES = 40
) (
   input  wire logic              ref_clk,
   output var awm_pkg::awm_runin_s runIn
);
   initial runIn = 4'h0;
   task automatic setRun(input logic f, input logic r, input logic p);
      @(negedge ref_clk);
      runIn = {f, r, runIn.faultClear, p};
   endtask
   // Hold is shortened in sim; the device acts only on the release
   task automatic clearReq(input logic keepRun);
      @(negedge ref_clk);
      if (!keepRun) begin
         runIn.fwdRun = 1'b0;
         runIn.revRun = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      runIn.faultClear = 1'b1;
      repeat (HOLD_CYCLES) @(negedge ref_clk);
      runIn.faultClear = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam int CONF = 20;
   localparam int ERAS = 10;
   logic                  ref_clk;
   logic                  resetn;
   awm_pkg::awm_runin_s   runIn;
   awm_pkg::awm_panel_s   panel;
   awm_pkg::awm_warnsrc_s warnSrc;
   logic                  alarmEvent;
   logic                  startupFault;
   logic                  motorEnable;
   logic                  motorDir;
   logic                  warning_output;
   logic                  alarmActive;
   logic                  displayBlink;
   logic [1:0]            displayView;
   logic [7:0]            alarmCode;
   logic [7:0]            alarmHistTop;
   logic [7:0]            warnHistTop;
   logic [31:0]           lfsr;
   int                    err_total;
   int                    n_tests;
   int                    aq[$];
   int                    wq[$];
   logic [7:0]            wCode[3] = '{8'h6C, 8'h30, 8'h21};
   awm_alarm_warning_manager #(.CONFIRM_CYCLES(CONF), .ERASE_CYCLES(ERAS)) u_dut (
      .ref_clk, .resetn, .runIn, .panel, .alarmEvent, .alarmCode, .startupFault,
      .warnSrc, .motorEnable, .motorDir, .warning_output, .alarmActive,
      .displayView, .displayBlink, .alarmHistTop, .warnHistTop);
   awm_ctrl_model #(.HOLD_CYCLES(40)) u_ctrl (.ref_clk, .runIn);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int top(input int q[$]);
      return (q.size() > 0) ? q[0] : 0;
   endfunction
   task automatic chk(input string n, input logic [7:0] got, input int exp);
      n_tests++;
      if (got !== exp[7:0]) begin
         err_total++;
         $display("[ERR] %s exp %0h got %0h", n, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic cmd(input int b);
      panel[b] = 1'b1;
      cyc(1);
      panel[b] = 1'b0;
      cyc(3);
   endtask
   task automatic raiseAlarm;
      lfsr = nextRand(lfsr);
      alarmCode = lfsr[7:0] | 8'h01;
      alarmEvent = 1'b1;
      cyc(1);
      alarmEvent = 1'b0;
      aq.push_front(alarmCode);
      if (aq.size() > 9) aq.pop_back();
      cyc(3);
      chk("alarmActive", alarmActive, 1);
      chk("motorEnable", motorEnable, 0);
      chk("displayView", displayView, 2);
      chk("alarmHistTop", alarmHistTop, top(aq));
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      end_sim();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn = 1'b0;
      panel = 4'h1;
      warnSrc = 3'h0;
      alarmEvent = 1'b0;
      alarmCode = 8'h00;
      startupFault = 1'b0;
      err_total = 0;
      n_tests = 0;
      lfsr = 32'h9C1B;
      cyc(12);
      resetn = 1'b1;
      cyc(1);
      chk("displayView", displayView, 0);
      chk("warnHistTop", warnHistTop, 0);
      u_ctrl.setRun(1, 1, 0);
      cyc(8);
      chk("motorEnable", motorEnable, 0);
      u_ctrl.setRun(0, 1, 0);
      cyc(8);
      chk("motorDir", {motorEnable, motorDir}, 3);
      for (int i = 0; i < 3; i++) begin
         warnSrc[i] = 1'b1;
         wq.push_front(wCode[i]);
         cyc(3);
         chk("warning_output", warning_output, 1);
         chk("warnHistTop", warnHistTop, top(wq));
         chk("motorEnable", motorEnable, i != 0);
         warnSrc = 3'h0;
         cyc(3);
      end
      cmd(1);
      wq.delete();
      chk("warnHistTop", warnHistTop, top(wq));
      repeat (10) raiseAlarm();
      u_ctrl.clearReq(1);
      cyc(8);
      chk("alarmActive", alarmActive, 1);
      u_ctrl.clearReq(0);
      chk("alarmActive", alarmActive, 1);
      cyc(8);
      chk("cleared", {alarmActive, motorEnable, displayView}, 1);
      cyc(CONF + 4);
      chk("displayView", displayView, 0);
      raiseAlarm();
      cmd(3);
      chk("alarmActive", alarmActive, 1);
      u_ctrl.setRun(0, 0, 1);
      cyc(8);
      u_ctrl.setRun(0, 0, 0);
      cyc(8);
      cmd(3);
      chk("panelClear", {alarmActive, displayView}, 1);
      cyc(CONF + 4);
      for (int m = 1; m >= 0; m--) begin
         panel.extOpMode = m[0];
         u_ctrl.setRun(m[0], 0, !m[0]);
         cyc(8);
         startupFault = 1'b1;
         cyc(1);
         startupFault = 1'b0;
         cyc(3);
         chk("startupSet", alarmActive, 1);
         u_ctrl.setRun(0, 0, 0);
         cyc(8);
         chk("startupClr", alarmActive, 0);
         cyc(CONF + 4);
      end
      raiseAlarm();
      warnSrc.overheat = 1'b1;
      wq.push_front(8'h21);
      cyc(3);
      chk("warnHistTop", warnHistTop, top(wq));
      warnSrc = 3'h0;
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      wq.delete();
      cyc(2);
      chk("alarmHistTop", alarmHistTop, top(aq));
      chk("warnHistTop", warnHistTop, top(wq));
      chk("powerCycle", {alarmActive, displayView}, 0);
      panel.extOpMode = 1'b1;
      cmd(2);
      chk("displayBlink", displayBlink, 1);
      raiseAlarm();
      cyc(ERAS + 4);
      chk("alarmActive", alarmActive, 1);
      aq.delete();
      chk("displayBlink", displayBlink, 0);
      chk("alarmHistTop", alarmHistTop, top(aq));
      end_sim();
   end
endmodule
`default_nettype wire
